// [logic/sse_exec.sv]
// executor for stop, subtract and nibble swap between decoder and regs
`timescale 1ns/1ns

module sse_exec
  import sse_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [7:0] opcode,
  input wire logic [7:0] op_byte1,
  input wire logic [7:0] op_byte2,
  input wire logic [3:0] work_base,
  output logic instr_done,
  output logic rf_rd_en,
  output logic [7:0] rf_rd_addr,
  input wire logic [7:0] rf_rd_data,
  output logic rf_we,
  output logic [7:0] rf_wr_addr,
  output logic [7:0] rf_wr_data,
  input wire logic [7:0] flags_in,
  output logic flags_we,
  output logic [7:0] flags_out,
  input wire logic ext_int,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic stopped
);

  // ==========================================================
  // decode helpers
  function automatic logic known_op(input logic [7:0] op);
    known_op = (op == OPC_STOP) || (op == OPC_SUB_RR_W) ||
               (op == OPC_SUB_RI_W) || (op == OPC_SUB_RR) ||
               (op == OPC_SUB_RI) || (op == OPC_SUB_IM) ||
               (op == OPC_SWAP_R) || (op == OPC_SWAP_IR);
  endfunction : known_op

  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    if (op == OPC_STOP)
      op_cycles = CYC_STOP;
    else if ((op == OPC_SUB_RR_W) || (op == OPC_SWAP_R) ||
             (op == OPC_SWAP_IR))
      op_cycles = CYC_SHORT;
    else
      op_cycles = CYC_LONG;
  endfunction : op_cycles

  function automatic logic [7:0] wreg(input logic [3:0] base,
                                      input logic [3:0] nib);
    wreg = {base, nib};
  endfunction : wreg

  sse_state_t state;
  logic [2:0] cnt;
  logic [2:0] last;
  logic is_stop;
  logic is_swap;
  logic src_ind;
  logic dst_ind;
  logic use_imm;
  logic [7:0] src_addr;
  logic [7:0] dst_addr;
  logic [7:0] src_val;
  logic take;
  logic wake;
  logic running;
  logic [7:0] alu_result;
  logic [7:0] alu_flags;
  logic src_step1;
  logic src_step2;
  logic dst_ptr_step;
  logic dst_step;

  // ==========================================================
  // wake pin synchroniser
  sse_wake_sync u_wake
  (
    .clk(clk),
    .rst_n(rst_n),
    .ext_int(ext_int),
    .int_sync(wake)
  );

  // ==========================================================
  // handshake and stage decode
  assign instr_ready = (state == SSE_IDLE);
  assign take = instr_valid && instr_ready && known_op(opcode);
  assign running = (state == SSE_RUN);
  assign instr_done = running && (cnt == last);
  assign src_step1 = running && !is_stop && !is_swap && !use_imm &&
                     (cnt == 3'h1);
  assign src_step2 = running && !is_swap && src_ind && (cnt == 3'h2);
  assign dst_ptr_step = running && is_swap && dst_ind && (cnt == 3'h1);
  // destination is always fetched the cycle before write-back
  assign dst_step = running && !is_stop && (cnt == last - 3'h1);

  // register file read port, combinational data back
  always_comb
  begin
    rf_rd_en = 1'b0;
    rf_rd_addr = BYTE_RST;
    if (src_step1 || src_step2)
    begin
      rf_rd_en = 1'b1;
      rf_rd_addr = src_addr;
    end
    else if (dst_ptr_step || dst_step)
    begin
      rf_rd_en = 1'b1;
      rf_rd_addr = dst_addr;
    end
  end

  // ==========================================================
  // datapath
  sse_alu u_alu
  (
    .do_swap(is_swap),
    .dst(rf_rd_data),
    .src(src_val),
    .flags_in(flags_in),
    .result(alu_result),
    .flags_out(alu_flags)
  );

  // ==========================================================
  // state sequencing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= SSE_IDLE;
    else
    begin
      unique case (state)
        SSE_IDLE:
          if (take)
            state <= SSE_RUN;
        SSE_RUN:
          if (cnt == last)
            state <= is_stop ? SSE_STOP : SSE_IDLE;
        SSE_STOP:
          if (wake)
            state <= SSE_IDLE;
        default:
          state <= SSE_IDLE;
      endcase
    end
  end

  // cycle counter, cycle 0 is the accept cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= CNT_RST;
    else if (take)
      cnt <= 3'h1;
    else if (running)
      cnt <= cnt + 3'h1;
    else
      cnt <= CNT_RST;
  end

  // ==========================================================
  // instruction capture and operand resolution
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last <= CNT_RST;
      is_stop <= 1'b0;
      is_swap <= 1'b0;
      src_ind <= 1'b0;
      dst_ind <= 1'b0;
      use_imm <= 1'b0;
      src_addr <= BYTE_RST;
      dst_addr <= BYTE_RST;
    end
    else if (take)
    begin
      last <= op_cycles(opcode) - 3'h1;
      is_stop <= (opcode == OPC_STOP);
      is_swap <= (opcode == OPC_SWAP_R) || (opcode == OPC_SWAP_IR);
      src_ind <= (opcode == OPC_SUB_RI_W) || (opcode == OPC_SUB_RI);
      dst_ind <= (opcode == OPC_SWAP_IR);
      use_imm <= (opcode == OPC_SUB_IM);
      if ((opcode == OPC_SUB_RR_W) || (opcode == OPC_SUB_RI_W))
      begin
        dst_addr <= wreg(work_base, op_byte1[7:4]);
        src_addr <= wreg(work_base, op_byte1[3:0]);
      end
      else if ((opcode == OPC_SUB_RR) || (opcode == OPC_SUB_RI))
      begin
        src_addr <= op_byte1;
        dst_addr <= op_byte2;
      end
      else
      begin
        dst_addr <= op_byte1;
        src_addr <= BYTE_RST;
      end
    end
    else
    begin
      // pointer replaces the register address for indirect forms
      if (src_step1 && src_ind)
        src_addr <= rf_rd_data;
      if (dst_ptr_step)
        dst_addr <= rf_rd_data;
    end
  end

  // source operand latch
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      src_val <= BYTE_RST;
    else if (take)
      src_val <= op_byte2; // immediate byte, overwritten for the register-source subtract forms
    else if ((src_step1 && !src_ind) || src_step2)
      src_val <= rf_rd_data;
  end

  // ==========================================================
  // write-back, lands on the final cycle; stop never writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_we <= 1'b0;
      flags_we <= 1'b0;
      rf_wr_addr <= BYTE_RST;
      rf_wr_data <= BYTE_RST;
      flags_out <= BYTE_RST;
    end
    else
    begin
      rf_we <= dst_step;
      flags_we <= dst_step;
      if (dst_step)
      begin
        rf_wr_addr <= dst_addr;
        rf_wr_data <= alu_result;
        flags_out <= alu_flags;
      end
    end
  end

  // ==========================================================
  // clock enables: registers keep value because no write strobe is raised while stopped; clk keeps running
  assign stopped = (state == SSE_STOP);
  assign cpu_clk_en = !stopped;
  assign sys_clk_en = !stopped;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence take_stop_s;
    take && (opcode == OPC_STOP);
  endsequence

  sequence take_sub22_s;
    take && (opcode == OPC_SUB_RR_W);
  endsequence

  sequence take_sub24_s;
    take && (opcode == OPC_SUB_RR);
  endsequence

  sequence take_swap_ind_s;
    take && (opcode == OPC_SWAP_IR);
  endsequence

  stop_clocks_a: assert property (stopped |-> !cpu_clk_en && !sys_clk_en)
    else $error("clock enable high while stopped");

  stop_retain_a: assert property (stopped |-> !rf_we && !flags_we)
    else $error("write during stop");

  stop_hold_a: assert property (stopped && !wake |=> stopped)
    else $error("stop left without wake");

  stop_entry_a: assert property (take_stop_s |->
    ##3 (instr_done && !stopped) ##1 stopped)
    else $error("stop entry timing wrong");

  stop_noflag_a: assert property (take_stop_s |->
    (!flags_we && !rf_we) [*5])
    else $error("stop wrote flags or registers");

  sub_short_a: assert property (take_sub22_s |->
    ##3 (instr_done && rf_we && flags_we))
    else $error("opcode 22 not four cycles");

  sub_long_a: assert property (take_sub24_s |->
    (!rf_we) [*5] ##0 1'b1 ##0 1'b1 ##1 (instr_done && rf_we))
    else $error("opcode 24 not six cycles");

  sub_dflag_a: assert property (flags_we && !is_swap |->
    flags_out[FLG_D])
    else $error("decimal flag not set by subtract");

  zero_sign_a: assert property (flags_we |->
    (flags_out[FLG_Z] == (rf_wr_data == 8'h00)) &&
    (flags_out[FLG_S] == rf_wr_data[7]))
    else $error("zero or sign flag mismatch");

  swap_keep_a: assert property (flags_we && is_swap |->
    flags_out[FLG_D] == $past(flags_in[FLG_D]) &&
    flags_out[FLG_H] == $past(flags_in[FLG_H]))
    else $error("swap changed d or h");

  swap_ind_a: assert property (take_swap_ind_s ##1 rf_rd_en |->
    ##2 (rf_we && rf_wr_addr == $past(rf_rd_data, 2)))
    else $error("indirect swap wrote wrong address");

  wake_resume_a: assert property (stopped && wake |=>
    instr_ready && cpu_clk_en && sys_clk_en)
    else $error("no resume after wake");

endmodule : sse_exec

// [logic/sse_pkg.sv]
// shared constants and types for the subtract, swap and stop executor
package sse_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OPC_STOP = 8'h7F;
  localparam logic [7:0] OPC_SUB_RR_W = 8'h22;
  localparam logic [7:0] OPC_SUB_RI_W = 8'h23;
  localparam logic [7:0] OPC_SUB_RR = 8'h24;
  localparam logic [7:0] OPC_SUB_RI = 8'h25;
  localparam logic [7:0] OPC_SUB_IM = 8'h26;
  localparam logic [7:0] OPC_SWAP_R = 8'hF0;
  localparam logic [7:0] OPC_SWAP_IR = 8'hF1;

  // ==========================================================
  // cycle counts per instruction
  localparam logic [2:0] CYC_STOP = 3'h4;
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;

  // ==========================================================
  // flag bit positions in the flag register
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] CNT_RST = 3'h0;

  // ==========================================================
  // executor states
  typedef enum logic [1:0]
  {
    SSE_IDLE = 2'b00,
    SSE_RUN = 2'b01,
    SSE_STOP = 2'b10
  } sse_state_t;

endpackage : sse_pkg

// [logic/sse_wake_sync.sv]
// two-stage synchroniser for the external wake-up interrupt pin
`timescale 1ns/1ns
module sse_wake_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_int,
  output logic int_sync
);

  logic meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= 1'b0;
      int_sync <= 1'b0;
    end
    else
    begin
      meta <= ext_int;
      int_sync <= meta;
    end
  end

endmodule : sse_wake_sync

// [logic/sse_alu.sv]
// subtract and nibble-swap datapath with flag generation
`timescale 1ns/1ns
module sse_alu
  import sse_pkg::*;
(
  input wire logic do_swap,
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic [7:0] flags_in,
  output logic [7:0] result,
  output logic [7:0] flags_out
);

  logic [8:0] sum;
  logic [4:0] low_sum;

  // ==========================================================
  // dst + ~src + 1, so carry out means no borrow
  always_comb
  begin
    sum = {1'b0, dst} + {1'b0, ~src} + 9'h001;
    low_sum = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + 5'h01;
    flags_out = flags_in;
    if (do_swap)
    begin
      result = {dst[3:0], dst[7:4]};
      // carry and overflow left as they were; d and h untouched
      flags_out[FLG_Z] = (result == 8'h00);
      flags_out[FLG_S] = result[7];
    end
    else
    begin
      result = sum[7:0];
      flags_out[FLG_C] = ~sum[8];
      flags_out[FLG_Z] = (result == 8'h00);
      flags_out[FLG_S] = result[7];
      flags_out[FLG_V] = (dst[7] != src[7]) && (result[7] == src[7]);
      flags_out[FLG_D] = 1'b1;
      flags_out[FLG_H] = ~low_sum[4];
    end
  end

endmodule : sse_alu

// [tb/sse_rfm.sv]
// register file and flag register model facing the executor
`timescale 1ns/1ns
module sse_rfm
(
  input wire logic clk,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic we,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic flags_we,
  input wire logic [7:0] flags_new,
  output logic [7:0] flags
);
  // ==========================================================
  // storage
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;

  // same-cycle read; when idle the bus shows the inverse of the last value
  // so that a stray sample is never silently right
  assign rd_data = rd_en ? mem[rd_addr] : ~last;

  // writes land at the edge that ends the strobe cycle
  always @(posedge clk)
  begin
    if (rd_en)
      last <= mem[rd_addr];
    if (we)
      mem[wr_addr] <= wr_data;
    if (flags_we)
      flags <= flags_new;
  end
endmodule : sse_rfm

// [tb/testbench.sv]
// self-checking bench for the subtract, swap and stop executor
`timescale 1ns/1ns
module testbench
  import sse_pkg::*;
;
  // ==========================================================
  // signals
  logic clk, rst_n, instr_valid, instr_ready, instr_done, ext_int;
  logic rf_rd_en, rf_we, flags_we, cpu_clk_en, sys_clk_en, stopped;
  logic [7:0] opcode, op_byte1, op_byte2, rf_rd_addr, rf_rd_data;
  logic [7:0] rf_wr_addr, rf_wr_data, flags_in, flags_out;
  logic [3:0] work_base;
  logic [31:0] seed;
  integer fails = 0;
  integer checks_done = 0;
  int i, k;
  logic [23:0] dir [9] = '{24'h221200, 24'h231200, 24'h240201,
    24'h250201, 24'h260190, 24'h260165, 24'hF00000, 24'hF10200,
    24'h221100};
  logic [7:0] ops [7] = '{OPC_SUB_RR_W, OPC_SUB_RI_W, OPC_SUB_RR,
    OPC_SUB_RI, OPC_SUB_IM, OPC_SWAP_R, OPC_SWAP_IR};

  // ==========================================================
  // design and partner
  sse_exec u_sse_exec (.clk(clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_ready(instr_ready),
    .opcode(opcode), .op_byte1(op_byte1), .op_byte2(op_byte2),
    .work_base(work_base), .instr_done(instr_done),
    .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr),
    .rf_rd_data(rf_rd_data), .rf_we(rf_we), .rf_wr_addr(rf_wr_addr),
    .rf_wr_data(rf_wr_data), .flags_in(flags_in), .flags_we(flags_we),
    .flags_out(flags_out), .ext_int(ext_int), .cpu_clk_en(cpu_clk_en),
    .sys_clk_en(sys_clk_en), .stopped(stopped));
  sse_rfm u_sse_rfm (.clk(clk), .rd_en(rf_rd_en), .rd_addr(rf_rd_addr),
    .rd_data(rf_rd_data), .we(rf_we), .wr_addr(rf_wr_addr),
    .wr_data(rf_wr_data), .flags_we(flags_we), .flags_new(flags_out),
    .flags(flags_in));

  // ==========================================================
  // helpers
  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [7:0] exp_v, got);
    checks_done++;
    if (exp_v !== got)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp_v, got);
    end
  endtask : chk

  // result in the upper byte, new flags in the lower
  function automatic logic [15:0] expect_of(input logic [7:0] op, d, s, f);
    logic [7:0] r;
    logic [7:0] g;
    g = f;
    if (op[7])
      r = {d[3:0], d[7:4]};
    else
    begin
      r = d - s;
      g[FLG_C] = d < s;
      g[FLG_V] = (d[7] != s[7]) && (r[7] == s[7]);
      g[FLG_D] = 1'b1;
      g[FLG_H] = d[3:0] < s[3:0];
    end
    g[FLG_Z] = r == 8'h00;
    g[FLG_S] = r[7];
    return {r, g};
  endfunction : expect_of

  // one instruction; returns at the negedge of its last cycle, one negedge later for stop
  task automatic run(input logic [7:0] op, b1, b2, fl,
    input logic [3:0] wb);
    logic [7:0] da, sa, dv, sv;
    logic [15:0] e;
    int n;
    @(negedge clk);
    u_sse_rfm.flags = fl;
    work_base = wb;
    opcode = op;
    op_byte1 = b1;
    op_byte2 = b2;
    instr_valid = 1'b1;
    da = b1;
    sa = b1;
    if (op == OPC_SUB_RR_W || op == OPC_SUB_RI_W)
    begin
      da = {wb, b1[7:4]};
      sa = {wb, b1[3:0]};
    end
    if (op == OPC_SUB_RR || op == OPC_SUB_RI)
      da = b2;
    if (op == OPC_SUB_RI_W || op == OPC_SUB_RI)
      sa = u_sse_rfm.mem[sa];
    if (op == OPC_SWAP_IR)
      da = u_sse_rfm.mem[b1];
    dv = u_sse_rfm.mem[da];
    sv = (op == OPC_SUB_IM) ? b2 : u_sse_rfm.mem[sa];
    e = expect_of(op, dv, sv, fl);
    n = (op == OPC_SUB_RR_W || op[7] || op == OPC_STOP) ? 4 : 6;
    @(negedge clk);
    instr_valid = 1'b0;
    k = 1;
    while (instr_done !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    chk("cycles", 8'(n - 1), 8'(k));
    if (op == OPC_STOP)
    begin
      chk("stop_writes", 8'h00, {6'h00, rf_we, flags_we});
      @(negedge clk);
      chk("stop_pins", 8'h01, {5'h00, cpu_clk_en, sys_clk_en, stopped});
    end
    else
    begin
      chk("strobes", 8'h03, {6'h00, rf_we, flags_we});
      chk("wr_addr", da, rf_wr_addr);
      chk("result", e[15:8], rf_wr_data);
      chk("flags", e[7:0], flags_out);
    end
  endtask : run

  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // several times the expected run length, still far below the cap
  initial
  begin
    #(40 * 20000);
    fails++;
    report_and_stop();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 32'hB2C4ABAE;
    rst_n = 1'b0;
    instr_valid = 1'b0;
    opcode = 8'h00;
    op_byte1 = 8'h00;
    op_byte2 = 8'h00;
    work_base = 4'h0;
    ext_int = 1'b0;
    for (i = 0; i < 256; i++)
      u_sse_rfm.mem[i] = 8'($random(seed));
    u_sse_rfm.mem[1] = 8'h21;
    u_sse_rfm.mem[2] = 8'h03;
    u_sse_rfm.mem[3] = 8'h0A;
    // counted on rising edges: the clock's first settle to 0 counts as a falling edge
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    // corner cases, back to back
    for (i = 0; i < 9; i++)
      run(dir[i][23:16], dir[i][15:8], dir[i][7:0], 8'h00, 4'h0);
    // unknown opcode must not be taken
    opcode = 8'h27;
    instr_valid = 1'b1;
    repeat (3)
    begin
      @(negedge clk);
      chk("unknown", 8'h04, {5'h00, instr_ready, instr_done, rf_we});
    end
    instr_valid = 1'b0;
    // stop, offered work is refused, interrupt wakes
    run(OPC_STOP, 8'h00, 8'h00, 8'hA5, 4'h0);
    opcode = OPC_SUB_IM;
    instr_valid = 1'b1;
    repeat (8)
    begin
      @(negedge clk);
      chk("stop_hold", 8'h01, {4'h0, instr_ready, rf_we, flags_we,
        stopped});
    end
    instr_valid = 1'b0;
    ext_int = 1'b1;
    k = 0;
    while (stopped !== 1'b0 && k < 8)
    begin
      @(negedge clk);
      k++;
    end
    ext_int = 1'b0;
    @(negedge clk);
    chk("wake", 8'h0E, {4'h0, instr_ready, cpu_clk_en, sys_clk_en,
      stopped});
    chk("kept_flags", 8'hA5, flags_in);
    run(OPC_SWAP_R, 8'h03, 8'h00, 8'hA5, 4'h0);
    // stop released by reset held low for several cycles
    run(OPC_STOP, 8'h00, 8'h00, 8'h00, 4'h0);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("rst_wake", 8'h0E, {4'h0, instr_ready, cpu_clk_en, sys_clk_en,
      stopped});
    // random traffic
    for (i = 0; i < 300; i++)
      run(ops[{$random(seed)} % 7], 8'($random(seed)), 8'($random(seed)),
        8'($random(seed)), 4'($random(seed)));
    report_and_stop();
  end
endmodule : testbench
